// File: common/cmcs_pkg.sv
// Shared constants and types of the converter mode and clock status block
package cmcs_pkg;

  // ------------------------------------------------------------------
  // Register map (command codes on the management read port)
  // ------------------------------------------------------------------
  localparam logic [7:0] CMCS_ADDR_DEV_ID = 8'had;
  localparam logic [7:0] CMCS_ADDR_SI_REV = 8'hae;
  localparam logic [7:0] CMCS_ADDR_STATUS = 8'hdf;
  localparam logic [7:0] CMCS_STATUS_RESET = 8'h00;
  localparam logic [15:0] CMCS_RD_ZERO = 16'h0000;

  // ------------------------------------------------------------------
  // Status field positions
  // ------------------------------------------------------------------
  localparam int CMCS_ST_CLK_SRC = 0;
  localparam int CMCS_ST_PLL_LOCK = 1;
  localparam int CMCS_ST_SS_DONE = 2;
  localparam int CMCS_ST_SOFTON_DONE = 3;
  localparam int CMCS_ST_SRC_CHG = 4;
  localparam int CMCS_ST_LF_SHORT = 5;
  localparam int CMCS_ST_FREQ_LO = 6;
  localparam int CMCS_ST_FREQ_HI = 7;

  // ------------------------------------------------------------------
  // Mode pin levels and phase drive codes
  // ------------------------------------------------------------------
  localparam logic [1:0] CMCS_MODE_GND = 2'h0;
  localparam logic [1:0] CMCS_MODE_1V0 = 2'h1;
  localparam logic [1:0] CMCS_MODE_2V05 = 2'h2;
  localparam logic [1:0] CMCS_MODE_VCC = 2'h3;
  localparam logic [1:0] CMCS_DRV_LOW = 2'h0;
  localparam logic [1:0] CMCS_DRV_HIGH = 2'h1;
  localparam logic [1:0] CMCS_DRV_MID = 2'h2;
  localparam logic [1:0] CMCS_FREQ_UNUSED = 2'h3;
  localparam logic [1:0] CMCS_FREQ_OK = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CMCS_CLK_KHZ = 10000;
  localparam int CMCS_INIT_NS = 2000;
  localparam int CMCS_SOFTON_NS = 10000;
  localparam int CMCS_INIT_CYC =
    (CMCS_INIT_NS * CMCS_CLK_KHZ + 999999) / 1000000;
  localparam int CMCS_SOFTON_CYC =
    (CMCS_SOFTON_NS * CMCS_CLK_KHZ + 999999) / 1000000;
  localparam int CMCS_CLOCK_OUTPUT_PIN_DIV = 5;
  localparam int CMCS_TMR_W = 8;

  typedef enum logic [2:0] {
    CMCS_ST_UV,
    CMCS_ST_INIT,
    CMCS_ST_IDLE,
    CMCS_ST_SS,
    CMCS_ST_SOFTON,
    CMCS_ST_RUN,
    CMCS_ST_ZC
  } cmcs_state_e;

endpackage

// File: common/cmcs_tmr_if.sv
// Carrier between the sequencer and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface cmcs_tmr_if;
  logic start;
  logic [7:0] load;
  logic done;

  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// File: src/cmcs_divider.sv
// Enable pulse divider for slower rates
`timescale 1ns/1ps
`default_nettype none
module cmcs_divider
#(
  parameter int DIV = 5
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pulse out
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } cmcs_div_s;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  cmcs_div_s s_q;
  cmcs_div_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == LAST);
    s_d.cnt = (s_q.cnt == LAST) ? 8'h00 : s_q.cnt + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

// File: src/cmcs_timer.sv
// Down-counting interval timer, one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module cmcs_timer
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  cmcs_tmr_if.tmr t
);
  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic done;
  } cmcs_tmr_s;

  cmcs_tmr_s s_q;
  cmcs_tmr_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (t.start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = t.load;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt <= 8'h01)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign t.done = s_q.done;
endmodule
`default_nettype wire

// File: src/cmcs_top.sv
// Converter mode, clock status and identification register block
//
// Functional notes
// - status bit 0: external clock source flag
// - bit 1 lock; no clock out, no start unlocked
// - bit 2 set after soft-start finishes
// - bit 3 set when soft-on transition ends
// - bit 4 set on clock source change
// - bit 5 reports loop filter short
// - bits 7:6 frequency pin condition code
// - status register read-only, resets to zero
// - fixed identification code, writes ignored
// - fixed silicon revision code, read-only
// - direction input high boost, low buck
// - direction change: stop, zero cross, restart
// - tri-state outputs: high, low, mid off
// - two-level outputs show main switch only
// - mode pin latched at startup
// - diode emulation only with tri-state outputs
// - undervoltage resets, then restart sequence
`timescale 1ns/1ps
`default_nettype none
module cmcs_top
  import cmcs_pkg::*;
#(
  // Arbitrary values, not tied to any real part
  parameter logic [15:0] DEVICE_CODE = 16'h5a01,
  parameter logic [15:0] REVISION_CODE = 16'h0001
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register read and write commands
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic wr_req,
  input wire logic [7:0] wr_addr,
  output logic rd_valid_q,
  output logic [15:0] rd_data_q,
  output logic rd_err_q,
  output logic wr_err_q,
  // Control pins and straps
  input wire logic direction_select_input,
  input wire logic switching_enable,
  input wire logic output_state_select,
  input wire logic [1:0] mode_pin_level,
  input wire logic undervoltage_lockout,
  // Clock and loop monitors
  input wire logic ext_clock_present,
  input wire logic pll_locked,
  input wire logic loop_filter_short,
  input wire logic [1:0] frequency_set_pin,
  // Regulation loop handshakes
  input wire logic soft_start_done,
  input wire logic main_switch_on,
  input wire logic inductor_zero_cross,
  // Outputs
  output logic [1:0] phase_drive_outputs,
  output logic clock_output_pin,
  output logic boost_mode_q,
  output logic tri_mode_q,
  output logic diode_emulation_q,
  output logic hiccup_mode_q,
  output logic [7:0] status_q
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    cmcs_state_e st;
    logic boost;
    logic tri_mode;
    logic de_mode;
    logic hiccup;
    logic src_prev;
    logic src_chg;
    logic [1:0] drive;
    logic clk_out;
    logic rd_valid;
    logic [15:0] rd_data;
    logic rd_err;
    logic wr_err;
    logic [7:0] status;
  } cmcs_top_s;

  // Both intervals fit the 8-bit timer count
  localparam logic [7:0] INIT_LOAD = 8'(CMCS_INIT_CYC);
  localparam logic [7:0] SOFTON_LOAD = 8'(CMCS_SOFTON_CYC);

  cmcs_top_s s_q;
  cmcs_top_s s_d;
  logic clk_tick;
  logic tmr_start;
  logic [7:0] tmr_load;
  logic stat_read;
  logic switching;
  logic sync_allowed;
  logic [7:0] stat_next;

  cmcs_tmr_if tmr_bus ();

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  cmcs_divider #(
    .DIV (CMCS_CLOCK_OUTPUT_PIN_DIV)
  ) u_div (
    .clk_sys (clk_sys),
    .rstn (rstn),
    .tick (clk_tick)
  );

  cmcs_timer u_tmr (
    .clk_sys (clk_sys),
    .rstn (rstn),
    .t (tmr_bus.tmr)
  );

  assign tmr_bus.start = tmr_start;
  assign tmr_bus.load = tmr_load;

  // A status read clears the change flag unless a source change sets it in the same cycle
  assign stat_read = rd_req && (rd_addr == CMCS_ADDR_STATUS);
  assign switching = (s_q.st == CMCS_ST_SS) || (s_q.st == CMCS_ST_SOFTON) ||
    (s_q.st == CMCS_ST_RUN);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    tmr_start = 1'b0;
    tmr_load = INIT_LOAD;
    stat_next = CMCS_STATUS_RESET;
    sync_allowed = 1'b0;

    // clock source change
    // Set wins over a read clear in one cycle
    if (ext_clock_present != s_q.src_prev)
      s_d.src_chg = 1'b1;
    else if (stat_read)
      s_d.src_chg = 1'b0;
    s_d.src_prev = ext_clock_present;

    case (s_q.st)
      CMCS_ST_UV:
      begin
        if (!undervoltage_lockout)
        begin
          s_d.st = CMCS_ST_INIT;
          tmr_start = 1'b1;
          tmr_load = INIT_LOAD;
        end
      end
      CMCS_ST_INIT:
      begin
        if (tmr_bus.done)
        begin
          s_d.de_mode = output_state_select &&
            ((mode_pin_level == CMCS_MODE_GND) ||
            (mode_pin_level == CMCS_MODE_2V05));
          s_d.hiccup = (mode_pin_level == CMCS_MODE_GND) ||
            (mode_pin_level == CMCS_MODE_1V0);
          s_d.tri_mode = output_state_select;
          s_d.st = CMCS_ST_IDLE;
        end
      end
      CMCS_ST_IDLE:
      begin
        s_d.boost = direction_select_input;
        if (switching_enable && pll_locked)
          s_d.st = CMCS_ST_SS;
      end
      CMCS_ST_SS:
      begin
        if (soft_start_done)
        begin
          s_d.st = CMCS_ST_SOFTON;
          tmr_start = 1'b1;
          tmr_load = SOFTON_LOAD;
        end
      end
      CMCS_ST_SOFTON:
      begin
        if (tmr_bus.done)
          s_d.st = CMCS_ST_RUN;
      end
      CMCS_ST_RUN:
      begin
        s_d.st = CMCS_ST_RUN;
      end
      CMCS_ST_ZC:
      begin
        if (inductor_zero_cross)
        begin
          s_d.boost = direction_select_input;
          s_d.st = (switching_enable && pll_locked) ? CMCS_ST_SS :
            CMCS_ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = CMCS_ST_UV;
      end
    endcase

    // Aborts out of switching; direction change may come with enable high
    if (switching)
    begin
      if (!switching_enable || !pll_locked)
        s_d.st = CMCS_ST_IDLE;
      else if (direction_select_input != s_q.boost)
        s_d.st = CMCS_ST_ZC;
    end
    if (s_q.st == CMCS_ST_ZC && !switching_enable)
      s_d.st = CMCS_ST_IDLE;

    if (undervoltage_lockout)
      s_d.st = CMCS_ST_UV;

    // ----------------------------------------------------------------
    // Phase drive
    // ----------------------------------------------------------------
    // emulation needs mid level
    sync_allowed = (s_q.st == CMCS_ST_RUN) &&
      !(s_q.de_mode && s_q.tri_mode && inductor_zero_cross);
    // New strap value, so a re-latch leaves no stale level
    if (s_d.tri_mode)
    begin
      if (!switching)
        s_d.drive = CMCS_DRV_MID;
      else if (main_switch_on)
        s_d.drive = s_q.boost ? CMCS_DRV_LOW : CMCS_DRV_HIGH;
      else if (sync_allowed)
        s_d.drive = s_q.boost ? CMCS_DRV_HIGH : CMCS_DRV_LOW;
      else
        s_d.drive = CMCS_DRV_MID;
    end
    else
    begin
      s_d.drive = (switching && main_switch_on) ? CMCS_DRV_HIGH :
        CMCS_DRV_LOW;
    end
    if (s_d.st != s_q.st && (s_d.st == CMCS_ST_ZC ||
      s_d.st == CMCS_ST_UV || s_d.st == CMCS_ST_IDLE))
      s_d.drive = s_d.tri_mode ? CMCS_DRV_MID : CMCS_DRV_LOW;

    if (!pll_locked)
      s_d.clk_out = 1'b0;
    else if (clk_tick)
      s_d.clk_out = !s_q.clk_out;

    // ----------------------------------------------------------------
    // Status assembly
    // ----------------------------------------------------------------
    // clock source
    stat_next[CMCS_ST_CLK_SRC] = ext_clock_present;
    stat_next[CMCS_ST_PLL_LOCK] = pll_locked;
    stat_next[CMCS_ST_SS_DONE] = (s_q.st == CMCS_ST_SOFTON) ||
      (s_q.st == CMCS_ST_RUN);
    stat_next[CMCS_ST_SOFTON_DONE] = (s_q.st == CMCS_ST_RUN);
    stat_next[CMCS_ST_SRC_CHG] = s_d.src_chg;
    stat_next[CMCS_ST_LF_SHORT] = loop_filter_short;
    {stat_next[CMCS_ST_FREQ_HI], stat_next[CMCS_ST_FREQ_LO]} =
      (frequency_set_pin == CMCS_FREQ_UNUSED) ? CMCS_FREQ_OK :
      frequency_set_pin;
    s_d.status = stat_next;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    s_d.rd_valid = rd_req;
    s_d.rd_err = 1'b0;
    s_d.rd_data = CMCS_RD_ZERO;
    if (rd_req)
    begin
      case (rd_addr)
        CMCS_ADDR_DEV_ID: s_d.rd_data = DEVICE_CODE;
        CMCS_ADDR_SI_REV: s_d.rd_data = REVISION_CODE;
        CMCS_ADDR_STATUS: s_d.rd_data = {8'h00, s_q.status};
        // Unmapped reads answer zero with an error
        default: s_d.rd_err = 1'b1;
      endcase
    end
    s_d.wr_err = wr_req;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.st <= CMCS_ST_UV;
      s_q.status <= CMCS_STATUS_RESET;
    end
    else
      s_q <= s_d;
  end

  assign rd_valid_q = s_q.rd_valid;
  assign rd_data_q = s_q.rd_data;
  assign rd_err_q = s_q.rd_err;
  assign wr_err_q = s_q.wr_err;
  assign phase_drive_outputs = s_q.drive;
  assign clock_output_pin = s_q.clk_out;
  assign boost_mode_q = s_q.boost;
  assign tri_mode_q = s_q.tri_mode;
  assign diode_emulation_q = s_q.de_mode;
  assign hiccup_mode_q = s_q.hiccup;
  assign status_q = s_q.status;

endmodule
`default_nettype wire

// File: verification/cmcs_host_model.sv
// Host side model of the management register port
`timescale 1ns/1ps
`default_nettype none
module cmcs_host_model
(
  // Clock
  input wire logic clk_sys,
  // Requests
  output logic rd_req,
  output logic [7:0] rd_addr,
  output logic wr_req,
  output logic [7:0] wr_addr,
  // Answers
  input wire logic rd_valid_q,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_err_q,
  input wire logic wr_err_q
);
  initial
  begin
    rd_req = 1'b0;
    rd_addr = 8'h00;
    wr_req = 1'b0;
    wr_addr = 8'h00;
  end
  // Fixed one-cycle answer, so no wait loop is needed
  task automatic rd(input logic [7:0] a, output logic [17:0] r);
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_req = 1'b0;
    // Released address shows a changed value
    rd_addr = ~a;
    r = {rd_valid_q, rd_err_q, rd_data_q};
  endtask
  task automatic wr(input logic [7:0] a, output logic e);
    @(negedge clk_sys);
    wr_req = 1'b1;
    wr_addr = a;
    @(negedge clk_sys);
    wr_req = 1'b0;
    wr_addr = ~a;
    e = wr_err_q;
  endtask
endmodule
`default_nettype wire

// File: verification/cmcs_properties.sv
// Port checker for the mode and clock status block
`timescale 1ns/1ps
`default_nettype none
module cmcs_properties
  import cmcs_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h5a01,
  parameter logic [15:0] REVISION_CODE = 16'h0001
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic wr_req,
  input wire logic rd_valid_q,
  input wire logic [15:0] rd_data_q,
  input wire logic wr_err_q,
  // Pins and monitors
  input wire logic undervoltage_lockout,
  input wire logic ext_clock_present,
  input wire logic pll_locked,
  input wire logic [1:0] frequency_set_pin,
  input wire logic soft_start_done,
  // Outputs
  input wire logic [1:0] phase_drive_outputs,
  input wire logic clock_output_pin,
  input wire logic tri_mode_q,
  input wire logic diode_emulation_q,
  input wire logic [7:0] status_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  // source bit
  a_src_bit: assert property (1'b1 |=>
    status_q[0] == $past(ext_clock_present))
    else $error("clock source bit wrong");
  a_lock_bit: assert property (1'b1 |=>
    status_q[1] == $past(pll_locked))
    else $error("lock bit wrong");
  a_no_clock_output_pin: assert property (!pll_locked ##1 !pll_locked
    |-> !clock_output_pin)
    else $error("clock out while unlocked");
  a_ss_cause: assert property ($rose(status_q[2])
    |-> $past(soft_start_done))
    else $error("soft-start bit without ramp end");
  a_softon_wait: assert property ($rose(status_q[3])
    |-> $past(status_q[2], 50))
    else $error("soft-on bit too early");
  a_chg_flag: assert property ($changed(ext_clock_present)
    |=> status_q[4])
    else $error("source change not flagged");
  a_freq_code: assert property (frequency_set_pin != CMCS_FREQ_UNUSED
    |=> status_q[7:6] == $past(frequency_set_pin))
    else $error("frequency code wrong");
  a_uv_reset: assert property (undervoltage_lockout
    |-> ##2 status_q[3:2] == 2'h0)
    else $error("run state kept under undervoltage");
  // ----------------------------------------------------------------
  // Register port and modes
  // ----------------------------------------------------------------
  // identification read
  a_id_read: assert property (rd_req && rd_addr == CMCS_ADDR_DEV_ID
    |=> rd_valid_q && rd_data_q == DEVICE_CODE)
    else $error("identification read wrong");
  a_st_read: assert property (rd_req && rd_addr == CMCS_ADDR_STATUS
    |=> rd_valid_q && rd_data_q == {8'h00, $past(status_q)})
    else $error("status read wrong");
  a_wr_refused: assert property (wr_req |=> wr_err_q)
    else $error("write not refused");
  a_de_tri: assert property (diode_emulation_q |-> tri_mode_q)
    else $error("emulation without three-state");
  a_two_level: assert property (!tri_mode_q
    |-> phase_drive_outputs != CMCS_DRV_MID)
    else $error("mid level in two-level mode");
  c_two_high: cover property (!tri_mode_q &&
    phase_drive_outputs == CMCS_DRV_HIGH);
  c_softon: cover property ($rose(status_q[3]));
  c_write: cover property (wr_err_q);
  c_mid: cover property (phase_drive_outputs == CMCS_DRV_MID);
endmodule
bind cmcs_top cmcs_properties #(.DEVICE_CODE(DEVICE_CODE),
  .REVISION_CODE(REVISION_CODE)) chk_u (.clk_sys, .rstn, .rd_req, .rd_addr,
  .wr_req, .rd_valid_q, .rd_data_q, .wr_err_q, .undervoltage_lockout,
  .ext_clock_present, .pll_locked, .frequency_set_pin, .soft_start_done,
  .phase_drive_outputs, .clock_output_pin, .tri_mode_q, .diode_emulation_q,
  .status_q);
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the mode and clock status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmcs_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic rd_req, wr_req, rd_valid_q, rd_err_q, wr_err_q;
  logic [7:0] rd_addr, wr_addr, status_q;
  logic [15:0] rd_data_q;
  logic dir = 1'b0, en = 1'b0, tri_sel = 1'b0, uv = 1'b0, ext = 1'b0;
  logic lock = 1'b0, lf = 1'b0, ssd = 1'b0, main_on = 1'b0, zc = 1'b0;
  logic [1:0] mode = 2'h0, freq = 2'h0, drv;
  logic clk_o, boost, tri_q, de_q, hic_q;
  logic [17:0] r;
  logic e;
  int errors = 0;
  int checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  cmcs_top dut_u (.clk_sys, .rstn, .rd_req, .rd_addr, .wr_req, .wr_addr,
    .rd_valid_q, .rd_data_q, .rd_err_q, .wr_err_q,
    .direction_select_input(dir), .switching_enable(en),
    .output_state_select(tri_sel), .mode_pin_level(mode),
    .undervoltage_lockout(uv), .ext_clock_present(ext), .pll_locked(lock),
    .loop_filter_short(lf), .frequency_set_pin(freq),
    .soft_start_done(ssd), .main_switch_on(main_on),
    .inductor_zero_cross(zc), .phase_drive_outputs(drv),
    .clock_output_pin(clk_o), .boost_mode_q(boost), .tri_mode_q(tri_q),
    .diode_emulation_q(de_q), .hiccup_mode_q(hic_q), .status_q);
  cmcs_host_model host_u (.clk_sys, .rd_req, .rd_addr, .wr_req, .wr_addr,
    .rd_valid_q, .rd_data_q, .rd_err_q, .wr_err_q);
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    host_u.rd(CMCS_ADDR_STATUS, r);
    chk(r, {2'b10, 8'h00, CMCS_STATUS_RESET});
    host_u.wr(CMCS_ADDR_DEV_ID, e);
    chk(e, 1'b1);
    host_u.rd(CMCS_ADDR_DEV_ID, r);
    chk(r, {2'b10, 16'h5a01});
    host_u.rd(CMCS_ADDR_SI_REV, r);
    chk(r, {2'b10, 16'h0001});
    host_u.rd(8'h00, r);
    chk(r, {2'b11, CMCS_RD_ZERO});
  endtask
  task automatic t_status;
    ext = 1'b1;
    lf = 1'b1;
    freq = 2'h1;
    cyc(2);
    host_u.rd(CMCS_ADDR_STATUS, r);
    chk(r[7:0], 8'h71);
    host_u.rd(CMCS_ADDR_STATUS, r);
    chk(r[7:0], 8'h61);
    freq = 2'h3;
    cyc(2);
    chk(status_q, 8'h21);
    freq = 2'h2;
    lf = 1'b0;
    cyc(2);
    chk(status_q, 8'h81);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 5; i++)
    begin
      tri_sel = (i > 0);
      mode = i[1:0];
      uv = 1'b1;
      cyc(2);
      uv = 1'b0;
      cyc(30);
      chk({tri_q, de_q, hic_q},
        {tri_sel, tri_sel & ~mode[0], ~mode[1]});
    end
  endtask
  task automatic t_run;
    int n;
    lock = 1'b1;
    en = 1'b1;
    ssd = 1'b1;
    main_on = 1'b1;
    n = 0;
    while (status_q[3] !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      chk(1'b0, 1'b1);
      end_of_test();
    end
    chk({status_q[3:1], n >= CMCS_SOFTON_CYC}, 4'hf);
    chk(drv, CMCS_DRV_HIGH);
    main_on = 1'b0;
    cyc(2);
    chk(drv, CMCS_DRV_LOW);
    n = 0;
    repeat (12)
    begin
      e = clk_o;
      cyc(1);
      n += (clk_o !== e);
    end
    chk(n > 0, 1'b1);
  endtask
  task automatic t_dir;
    dir = 1'b1;
    cyc(8);
    chk({drv, boost}, {CMCS_DRV_MID, 1'b0});
    zc = 1'b1;
    cyc(4);
    chk({boost, status_q[3]}, 2'b10);
    lock = 1'b0;
    cyc(3);
    chk({clk_o, status_q[1], drv}, {2'b00, CMCS_DRV_MID});
  endtask
  task automatic t_two;
    int n;
    tri_sel = 1'b0;
    lock = 1'b1;
    main_on = 1'b1;
    uv = 1'b1;
    cyc(2);
    chk(status_q[3:2], 2'h0);
    uv = 1'b0;
    n = 0;
    while (status_q[2] !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    if (n >= 100)
    begin
      chk(1'b0, 1'b1);
      end_of_test();
    end
    chk({tri_q, de_q, drv}, {2'b00, CMCS_DRV_HIGH});
    main_on = 1'b0;
    cyc(2);
    chk(drv, CMCS_DRV_LOW);
  endtask
  initial
  begin
    cyc(12);
    rstn = 1'b1;
    t_regs();
    t_status();
    t_modes();
    t_run();
    t_dir();
    t_two();
    end_of_test();
  end
endmodule
`default_nettype wire
